// ### dv/tb_top.sv
`timescale 1ns/1ps
`include "lrc_defines.svh"
module tb_top
  import lrc_pkg::*;
;
  typedef struct {string nm; logic [31:0] v;} lrc_note_type;
  localparam logic [7:0] REV_CODE = 8'h3c; // Arbitrary value.
  localparam int STEP = `LRC_STEP1_CYC;
  localparam logic [7:0] IDX [7] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13};
  localparam logic [7:0] RST [7] = '{8'h92, 8'hf5, 8'h20, REV_CODE, 8'h9f, 8'h09, 8'h1a};
  localparam logic [7:0] MSK [7] = '{8'hfe, 8'hff, 8'hff, 8'h00, 8'hff, 8'h0f, 8'h1f};
  logic clk;
  logic rst_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic signal_level_limit;
  logic sync_and_node_match;
  logic packet_complete_flag;
  logic rx_timeout;
  logic receiver_on;
  logic fifo_flush;
  logic [2:0] current_mode;
  lrc_amp_cfg_type amp_cfg;
  int fails;
  int tests_run;
  int n;
  logic [31:0] seed;
  logic [7:0] cur [7];
  logic [7:0] d;
  lrc_note_type exp_q [$];
  lrc_note_type note;

  lrc_regs #(.REVISION_CODE(REV_CODE)) dut
  (
    .clk(clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .signal_level_limit(signal_level_limit),
    .sync_and_node_match(sync_and_node_match),
    .packet_complete_flag(packet_complete_flag),
    .rx_timeout(rx_timeout),
    .receiver_on(receiver_on),
    .fifo_flush(fifo_flush),
    .current_mode(current_mode),
    .amp_cfg(amp_cfg)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] near_step(input int k);
    return {31'h0, (k > STEP - 20) && (k < STEP + 20)};
  endfunction

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // The request is held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, v};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    check("bus_answer", 32'h1, {31'h0, k < 100});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back('{nm, e});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wait_rx(input logic lvl, output int k);
    k = 0;
    while (receiver_on !== lvl && k < 3 * STEP)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic start_listen(input logic [7:0] cfg, input logic [7:0] op);
    int k;
    bus(1'b1, 8'h0d, cfg);
    bus(1'b1, 8'h0e, 8'h01);
    bus(1'b1, 8'h0f, 8'h01);
    bus(1'b1, 8'h20, op);
    wait_rx(1'b1, k);
    check("idle_len", 32'h1, near_step(k));
  endtask

  task automatic stop_listen();
    bus(1'b1, 8'h20, 8'h24);
    cyc(4);
    check("rx_after_cancel", 32'h0, {31'h0, receiver_on});
    rd(8'h20, 32'h04, "op_after_cancel");
    rd(8'h21, 32'h1, "status_off");
  endtask

  // ****************************************
  // Clock, monitor and watchdog
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        check("unexpected_read", 32'h0, 32'h1);
      else
      begin
        note = exp_q.pop_front();
        check(note.nm, note.v, avs_readdata);
      end
    end
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    signal_level_limit = 1'b0;
    sync_and_node_match = 1'b0;
    packet_complete_flag = 1'b0;
    rx_timeout = 1'b0;
    fails = 0;
    tests_run = 0;
    seed = 32'h2c12;
    cyc(5);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      cur[i] = RST[i];
      rd(IDX[i], {24'h0, RST[i]}, "reset_value");
    end
    check("amp_cfg_reset", {15'h0, 8'h9f, 4'h9, 5'h1a}, {15'h0, amp_cfg});
    check("mode_reset", 32'h1, {29'h0, current_mode});
    rd(8'h20, 32'h04, "op_reset");
    for (int r = 0; r < 9; r++)
    begin
      for (int i = 0; i < 7; i++)
      begin
        seed = lfsr(seed);
        d = (r == 0) ? 8'hff : seed[7:0];
        if (i == 4 && (d[6] || d[5]))
          d[4] = 1'b1;
        bus(1'b1, IDX[i], d);
        cur[i] = (cur[i] & ~MSK[i]) | (d & MSK[i]);
        rd(IDX[i], {24'h0, cur[i]}, "readback");
      end
      check("amp_cfg", {15'h0, cur[4], cur[5][3:0], cur[6][4:0]}, {15'h0, amp_cfg});
    end
    for (int c = 0; c < 16; c++)
    begin
      bus(1'b1, 8'h12, {4'hf, 4'(c)});
      rd(8'h12, {28'h0, 4'(c)}, "ramp_code");
    end
    bus(1'b1, 8'h05, 8'hff);
    rd(8'h05, 32'h0, "unmapped");
    rd(8'h21, 32'h1, "status_idle_off");
    // Accept on signal level alone, then stay in receive.
    start_listen(8'h50, 8'h44);
    check("mode_rx", 32'h4, {29'h0, current_mode});
    rd(8'h21, 32'h4, "status_rx");
    signal_level_limit <= 1'b1;
    cyc(4);
    signal_level_limit <= 1'b0;
    cyc(STEP + 200);
    check("rx_hold", 32'h1, {31'h0, receiver_on});
    stop_listen();
    // Level alone is refused with the match rule; then accept and leave to mode 2.
    start_listen(8'h5a, 8'h48);
    signal_level_limit <= 1'b1;
    wait_rx(1'b0, n);
    check("rx_len", 32'h1, near_step(n));
    signal_level_limit <= 1'b0;
    wait_rx(1'b1, n);
    check("idle_again", 32'h1, near_step(n));
    signal_level_limit <= 1'b1;
    sync_and_node_match <= 1'b1;
    cyc(4);
    signal_level_limit <= 1'b0;
    sync_and_node_match <= 1'b0;
    packet_complete_flag <= 1'b1;
    cyc(1);
    packet_complete_flag <= 1'b0;
    cyc(4);
    check("mode_target", 32'h2, {29'h0, current_mode});
    cyc(STEP + 200);
    check("listen_stopped", 32'h0, {31'h0, receiver_on});
    stop_listen();
    // Resume idle after timeout and flush at the next wakeup.
    start_listen(8'h54, 8'h44);
    signal_level_limit <= 1'b1;
    cyc(4);
    signal_level_limit <= 1'b0;
    rx_timeout <= 1'b1;
    cyc(1);
    rx_timeout <= 1'b0;
    wait_rx(1'b0, n);
    check("resume_fast", 32'h1, {31'h0, n < 20});
    rd(8'h21, 32'h2, "status_resumed");
    n = 0;
    while (fifo_flush !== 1'b1 && n < 3 * STEP)
    begin
      @(posedge clk);
      n++;
    end
    check("flush_at_wakeup", 32'h1, near_step(n));
    cyc(2);
    check("rx_after_flush", 32'h1, {31'h0, receiver_on});
    stop_listen();
    cyc(10);
    print_verdict();
  end
endmodule

// ### hdl/lrc_defines.svh
`ifndef LRC_DEFINES_SVH
`define LRC_DEFINES_SVH
// Register word indices; byte address is four times the index.
`define LRC_IDX_LISTEN_CONFIG 8'h0d
`define LRC_IDX_IDLE_COEF 8'h0e
`define LRC_IDX_RX_COEF 8'h0f
`define LRC_IDX_REVISION 8'h10
`define LRC_IDX_AMP_LEVEL 8'h11
`define LRC_IDX_AMP_RAMP 8'h12
`define LRC_IDX_OCP 8'h13
// Own registers for the loose control and status bits.
`define LRC_IDX_OP_MODE 8'h20
`define LRC_IDX_LISTEN_STATUS 8'h21
// Reset values.
`define LRC_RST_LISTEN_CONFIG 8'h92
`define LRC_RST_IDLE_COEF 8'hf5
`define LRC_RST_RX_COEF 8'h20
`define LRC_RST_AMP_LEVEL 8'h9f
`define LRC_RST_AMP_RAMP 8'h09
`define LRC_RST_OCP 8'h1a
`define LRC_RST_MODE 3'h1
// Writable bit masks of the three registers with unused bits.
`define LRC_MSK_LISTEN_CONFIG 8'hfe
`define LRC_MSK_AMP_RAMP 8'h0f
`define LRC_MSK_OCP 8'h1f
// Field positions.
`define LRC_POS_OP_ENABLE 6
`define LRC_POS_OP_CANCEL 5
// Step times in ns and their cycle counts at 100 MHz (10 ns).
`define LRC_CLK_NS 10
`define LRC_STEP1_NS 64000
`define LRC_STEP2_NS 4100000
`define LRC_STEP3_NS 262000000
`define LRC_STEP1_CYC (`LRC_STEP1_NS / `LRC_CLK_NS)
`define LRC_STEP2_CYC (`LRC_STEP2_NS / `LRC_CLK_NS)
`define LRC_STEP3_CYC (`LRC_STEP3_NS / `LRC_CLK_NS)
`endif

// ### hdl/lrc_phase_counter.sv
`timescale 1ns/1ps
// Counts resolution steps of one listen phase and flags its last step.
module lrc_phase_counter
  import lrc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  input wire logic step_tick,
  input wire logic [7:0] coefficient,
  // Result
  output logic phase_done
);
  logic [7:0] steps_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      steps_reg <= 8'h0;
    else if (restart || phase_done)
      steps_reg <= 8'h0;
    else if (step_tick)
      steps_reg <= steps_reg + 8'h1; // RULE3 RULE4
  end

  // A zero coefficient ends the phase after one step.
  assign phase_done = step_tick && ((steps_reg + 8'h1 >= coefficient) || coefficient == 8'h0);
endmodule

// ### hdl/lrc_pkg.sv
package lrc_pkg;
  typedef enum logic [2:0]
  {
    LRC_PH_OFF = 3'b001,
    LRC_PH_IDLE = 3'b010,
    LRC_PH_RX = 3'b100
  } lrc_phase_type;

  typedef struct packed
  {
    logic [1:0] idle_step_select;
    logic [1:0] rx_step_select;
    logic accept_rule_bit;
    logic [1:0] after_accept_action;
  } lrc_listen_cfg_type;

  typedef struct packed
  {
    logic main_amp_enable;
    logic boost_amp_a_enable;
    logic boost_amp_b_enable;
    logic [4:0] tx_level_code;
    logic [3:0] ramp_time_code;
    logic current_limit_enable;
    logic [3:0] current_limit_trim;
  } lrc_amp_cfg_type;
endpackage

// ### hdl/lrc_regs.sv
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "lrc_defines.svh"
// How it works
// RULE1: Idle step field 01=64us, 10=4.1ms, 11=262ms, 00 reserved; default 10.
// RULE2: Receive step field uses the same encoding; default 01.
// RULE3: Idle phase lasts idle coefficient times idle step; coefficient resets to f5.
// RULE4: Receive phase lasts rx coefficient times rx step, startup included; resets 20.
// RULE5: Accept bit 0 needs signal level only; 1 also needs sync match.
// RULE6: Action 00 stays in receive after acceptance, listening stops; software clears enable.
// RULE7: Action 01 waits packet end or timeout, enters programmed mode, stops listening.
// RULE8: Action 10 waits packet end or timeout, resumes idle, flushes buffer next wakeup.
// RULE9: Revision register is read-only: upper nibble silicon, lower nibble metal revision.
// RULE10: Amp enables bit 7 main (on), bits 6 and 5 boost (off).
// RULE11: Five-bit level code in 1 dB steps; resets to all ones.
// RULE12: Software programs only upper sixteen level codes when a boost amp is used.
// RULE13: Four-bit ramp code selects rise and fall time; default 1001, upper nibble unused.
// RULE14: Overcurrent bit 4 enables protection; enabled after reset.
// RULE15: Four-bit trim sets limit 45 mA plus 5 mA per step; default 1010.
// RULE16: Enable bit starts listening; cancel with enable cleared aborts; cancel reads zero.
// RULE17: Three-bit mode field 000..100 is post-listen target; reads return current mode.
// RULE18: While enabled, idle and receive phases alternate, counted in selected steps.
// RULE19: Unused bits read zero and ignore writes.
module lrc_regs
  import lrc_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h11 // Arbitrary value.
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Radio core events
  input wire logic signal_level_limit,
  input wire logic sync_and_node_match,
  input wire logic packet_complete_flag,
  input wire logic rx_timeout,
  // Controls to the radio core
  output logic receiver_on,
  output logic fifo_flush,
  output logic [2:0] current_mode,
  output lrc_amp_cfg_type amp_cfg
);
  logic [7:0] cfg_reg;
  logic [7:0] idle_coef_reg;
  logic [7:0] rx_coef_reg;
  logic [7:0] level_reg;
  logic [3:0] ramp_reg;
  logic [4:0] ocp_reg;
  logic [2:0] mode_reg;
  logic enable_reg;
  logic hold_rx_reg;
  logic flush_pend_reg;
  logic wait_reg;
  logic halt_reg;
  logic [31:0] rdata_reg;
  logic fifo_flush_reg;
  lrc_phase_type phase_reg;
  lrc_phase_type phase_next;
  lrc_listen_cfg_type lcfg;
  logic wr;
  logic rd;
  logic step_tick;
  logic phase_done;
  logic accept;
  logic rx_end;
  logic cancel;
  logic [7:0] rdata;

  assign lcfg = cfg_reg[7:1];
  // A write lands at the edge that sees waitrequest low; read data is captured one edge earlier.
  assign wr = avs_write && !wait_reg;
  assign rd = avs_read && wait_reg;
  assign cancel = wr && avs_address == `LRC_IDX_OP_MODE
    && avs_writedata[`LRC_POS_OP_CANCEL] && !avs_writedata[`LRC_POS_OP_ENABLE];

  // ************************************************************
  // Register bus
  // ************************************************************
  // Every access takes two cycles: waitrequest drops in the second.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_reg <= 1'b1;
    else
      wait_reg <= !((avs_read || avs_write) && wait_reg);
  end

  assign avs_waitrequest = wait_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg <= `LRC_RST_LISTEN_CONFIG; // RULE1 RULE2
      idle_coef_reg <= `LRC_RST_IDLE_COEF; // RULE3
      rx_coef_reg <= `LRC_RST_RX_COEF; // RULE4
      level_reg <= `LRC_RST_AMP_LEVEL; // RULE10 RULE11
      ramp_reg <= 4'(`LRC_RST_AMP_RAMP); // RULE13
      ocp_reg <= 5'(`LRC_RST_OCP); // RULE14 RULE15
    end
    else if (wr)
    begin
      unique case (avs_address)
        `LRC_IDX_LISTEN_CONFIG: cfg_reg <= avs_writedata[7:0] & `LRC_MSK_LISTEN_CONFIG; // RULE19
        `LRC_IDX_IDLE_COEF: idle_coef_reg <= avs_writedata[7:0];
        `LRC_IDX_RX_COEF: rx_coef_reg <= avs_writedata[7:0];
        `LRC_IDX_AMP_LEVEL: level_reg <= avs_writedata[7:0]; // RULE10 RULE11
        `LRC_IDX_AMP_RAMP: ramp_reg <= avs_writedata[3:0]; // RULE13
        `LRC_IDX_OCP: ocp_reg <= avs_writedata[4:0]; // RULE14 RULE15
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= `LRC_RST_MODE;
      enable_reg <= 1'b0;
    end
    else if (wr && avs_address == `LRC_IDX_OP_MODE)
    begin
      mode_reg <= avs_writedata[4:2]; // RULE17
      enable_reg <= avs_writedata[`LRC_POS_OP_ENABLE]; // RULE16
    end
  end

  always_comb
  begin
    unique case (avs_address)
      `LRC_IDX_LISTEN_CONFIG: rdata = cfg_reg;
      `LRC_IDX_IDLE_COEF: rdata = idle_coef_reg;
      `LRC_IDX_RX_COEF: rdata = rx_coef_reg;
      `LRC_IDX_REVISION: rdata = REVISION_CODE; // RULE9
      `LRC_IDX_AMP_LEVEL: rdata = level_reg;
      `LRC_IDX_AMP_RAMP: rdata = {4'h0, ramp_reg}; // RULE19
      `LRC_IDX_OCP: rdata = {3'h0, ocp_reg}; // RULE19
      `LRC_IDX_OP_MODE: rdata = {1'b0, enable_reg, 1'b0, current_mode, 2'h0}; // RULE16 RULE17
      `LRC_IDX_LISTEN_STATUS: rdata = {5'h0, phase_reg};
      default: rdata = 8'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 32'h0;
    else if (rd)
      rdata_reg <= {24'h0, rdata};
  end

  assign avs_readdata = rdata_reg;

  // ************************************************************
  // Listen sequencer
  // ************************************************************
  assign accept = signal_level_limit && (!lcfg.accept_rule_bit || sync_and_node_match); // RULE5
  assign rx_end = packet_complete_flag || rx_timeout;

  lrc_step_timer u_step
  (
    .clk(clk),
    .rst_n(rst_n),
    .run(phase_reg != LRC_PH_OFF && !hold_rx_reg),
    .step_select(phase_reg == LRC_PH_IDLE ? lcfg.idle_step_select : lcfg.rx_step_select),
    .step_tick(step_tick)
  );

  lrc_phase_counter u_phase
  (
    .clk(clk),
    .rst_n(rst_n),
    .restart(phase_reg == LRC_PH_OFF || hold_rx_reg),
    .step_tick(step_tick),
    .coefficient(phase_reg == LRC_PH_IDLE ? idle_coef_reg : rx_coef_reg),
    .phase_done(phase_done)
  );

  always_comb
  begin
    phase_next = phase_reg;
    unique case (phase_reg)
      LRC_PH_OFF:
        if (enable_reg && !halt_reg)
          phase_next = LRC_PH_IDLE;
      LRC_PH_IDLE:
        if (phase_done)
          phase_next = LRC_PH_RX; // RULE18
      LRC_PH_RX:
        if (hold_rx_reg && rx_end && lcfg.after_accept_action == 2'h2)
          phase_next = LRC_PH_IDLE; // RULE8
        else if (hold_rx_reg && rx_end && lcfg.after_accept_action == 2'h1)
          phase_next = LRC_PH_OFF; // RULE7
        else if (!hold_rx_reg && accept && lcfg.after_accept_action == 2'h0)
          phase_next = LRC_PH_OFF; // RULE6
        else if (!hold_rx_reg && phase_done)
          phase_next = LRC_PH_IDLE; // RULE4 RULE18
      default: phase_next = LRC_PH_OFF;
    endcase
    if (cancel || !enable_reg)
      phase_next = LRC_PH_OFF; // RULE16
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_reg <= LRC_PH_OFF;
    else
      phase_reg <= phase_next;
  end

  // Acceptance freezes the receive phase timer until the packet ends.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_rx_reg <= 1'b0;
    else if (phase_next != LRC_PH_RX)
      hold_rx_reg <= 1'b0;
    else if (phase_reg == LRC_PH_RX && accept && !hold_rx_reg)
      hold_rx_reg <= 1'b1;
  end

  // Mode seen by the radio: receive in the receive phase and after an 00 stop.
  // A stop by action 00 or 01 keeps listening off until software clears the enable.
  logic stay_rx_reg;
  logic stay_rx_now;

  assign stay_rx_now = enable_reg && !cancel && (stay_rx_reg || (phase_reg == LRC_PH_RX
    && phase_next == LRC_PH_OFF && lcfg.after_accept_action == 2'h0));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stay_rx_reg <= 1'b0;
      halt_reg <= 1'b0;
    end
    else if (!enable_reg || cancel)
    begin
      stay_rx_reg <= 1'b0;
      halt_reg <= 1'b0;
    end
    else if (phase_reg == LRC_PH_RX && phase_next == LRC_PH_OFF)
    begin
      stay_rx_reg <= lcfg.after_accept_action == 2'h0; // RULE6
      halt_reg <= 1'b1; // RULE6 RULE7
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receiver_on <= 1'b0;
      current_mode <= `LRC_RST_MODE;
    end
    else
    begin
      receiver_on <= phase_next == LRC_PH_RX || stay_rx_now;
      current_mode <= (phase_next == LRC_PH_RX || stay_rx_now) ? 3'h4
        : (phase_next == LRC_PH_IDLE ? `LRC_RST_MODE : mode_reg); // RULE7 RULE17
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flush_pend_reg <= 1'b0;
      fifo_flush_reg <= 1'b0;
    end
    else
    begin
      fifo_flush_reg <= flush_pend_reg && phase_reg == LRC_PH_IDLE && phase_next == LRC_PH_RX;
      if (phase_reg == LRC_PH_RX && hold_rx_reg && phase_next == LRC_PH_IDLE)
        flush_pend_reg <= 1'b1; // RULE8
      else if (phase_next == LRC_PH_RX || phase_next == LRC_PH_OFF)
        flush_pend_reg <= 1'b0;
    end
  end

  assign fifo_flush = fifo_flush_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      amp_cfg <= {1'b1, 1'b0, 1'b0, 5'h1f, 4'h9, 1'b1, 4'ha};
    else
      amp_cfg <= {level_reg, ramp_reg, ocp_reg}; // RULE12 left to software
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_idle_end;
    phase_reg == LRC_PH_IDLE && phase_done && enable_reg && !cancel;
  endsequence

  AST_IDLE_TO_RX: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    s_idle_end |=> phase_reg == LRC_PH_RX)
    else $error("idle phase did not hand over to receive");
  AST_CANCEL: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    cancel |=> phase_reg == LRC_PH_OFF)
    else $error("cancel did not stop listening");
  AST_RX_ON: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    phase_reg == LRC_PH_RX |-> receiver_on)
    else $error("receiver off in receive phase");
  AST_STRICT_ACCEPT: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    phase_reg == LRC_PH_RX && !hold_rx_reg && lcfg.accept_rule_bit && !sync_and_node_match
      && !phase_done && enable_reg && !cancel |=> phase_reg == LRC_PH_RX && !hold_rx_reg)
    else $error("accepted without sync match");
  AST_RAMP_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    !wait_reg && $past(avs_address) == `LRC_IDX_AMP_RAMP && $past(avs_read)
      |=> avs_readdata[31:4] == 28'h0)
    else $error("unused ramp bits read nonzero");
  AST_REV: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    rd && avs_address == `LRC_IDX_REVISION |=> avs_readdata[7:0] == REVISION_CODE)
    else $error("revision read wrong");
  AST_STOP00: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    phase_reg == LRC_PH_RX && !hold_rx_reg && accept && lcfg.after_accept_action == 2'h0
      && enable_reg && !cancel |=> receiver_on && phase_reg == LRC_PH_OFF
      ##1 receiver_on && phase_reg == LRC_PH_OFF)
    else $error("action 00 did not stay in receive");
  AST_RESUME10: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    phase_reg == LRC_PH_RX && hold_rx_reg && rx_end && lcfg.after_accept_action == 2'h2
      && enable_reg && !cancel |=> phase_reg == LRC_PH_IDLE && flush_pend_reg)
    else $error("action 10 did not resume idle");
endmodule

// ### hdl/lrc_step_timer.sv
`timescale 1ns/1ps
`include "lrc_defines.svh"
// Produces one pulse per resolution step by counting clk cycles.
module lrc_step_timer
  import lrc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [1:0] step_select,
  // Tick
  output logic step_tick
);
  logic [31:0] cnt_reg;
  logic [31:0] limit;

  always_comb
  begin
    unique case (step_select)
      2'h1: limit = 32'(`LRC_STEP1_CYC); // RULE1 RULE2
      2'h3: limit = 32'(`LRC_STEP3_CYC);
      default: limit = 32'(`LRC_STEP2_CYC);
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 32'h0;
    else if (!run || step_tick)
      cnt_reg <= 32'h0;
    else
      cnt_reg <= cnt_reg + 32'h1;
  end

  assign step_tick = run && (cnt_reg == limit - 32'h1);
endmodule
